// ==== conv_seq_pkg.sv ====
// Constants, state codes and timing figures for the conversion sequencer.
// Assumes a single master clock domain; figures are master clock cycles, except high-speed settling counts, which are slow ticks.
//
// Behaviour
// - Start level is registered on each rising master clock edge before use.
// - One start pulse yields exactly one conversion.
// - Start held high keeps conversions running back to back at path timing.
// - A new start pulse mid-conversion flushes it and begins afresh.
// - Result-ready rises only after the selected filter fully settles, except for the first high-speed fast-response result, flagged unsettled.
// - Filter path select 1 picks low-latency, 0 picks wide-bandwidth.
// - Low-latency config 0 is single-cycle settling, 1 is fast response.
// - Single-cycle settling results use only the preceding conversion period.
// - Single-cycle settling codes 000-011 settle in 556/300/172/116 clocks.
// - Fast response rates 125k-4000k; settle 556/300/172/116 clocks, 265/229 slow ticks.
// - High-speed fast response: first result after start is flagged unsettled.
// - Rate codes 100 and 101 select high-speed mode; others low-speed.
// - Low-latency config low forces the low-latency path over path select.
// - Wide-bandwidth path waits for full settling after start before ready.
package conv_seq_pkg;

  // ****************************************************************
  // Widths and rate codes
  // ****************************************************************
  localparam int unsigned CNT_W          = 14;
  localparam int unsigned RATE_W         = 3;
  localparam logic [2:0]  RATE_125K      = 3'h0;
  localparam logic [2:0]  RATE_250K      = 3'h1;
  localparam logic [2:0]  RATE_500K      = 3'h2;
  localparam logic [2:0]  RATE_1000K     = 3'h3;
  localparam logic [2:0]  RATE_2000K     = 3'h4;
  localparam logic [2:0]  RATE_4000K     = 3'h5;
  localparam logic        PATH_LL        = 1'b1;
  localparam logic        CFG_FAST       = 1'b1;

  // ****************************************************************
  // Settling counts (low-latency in master clocks, high speed in slow ticks)
  // ****************************************************************
  localparam logic [13:0] LL_SETTLE_0    = 14'h022c;  // 556 clocks.
  localparam logic [13:0] LL_SETTLE_1    = 14'h012c;  // 300 clocks.
  localparam logic [13:0] LL_SETTLE_2    = 14'h00ac;  // 172 clocks.
  localparam logic [13:0] LL_SETTLE_3    = 14'h0074;  // 116 clocks.
  localparam logic [13:0] LL_SETTLE_4    = 14'h0109;  // 265 slow ticks.
  localparam logic [13:0] LL_SETTLE_5    = 14'h00e5;  // 229 slow ticks.
  localparam int unsigned WB_SETTLE_0    = 14062;     // Above 4096: top parameter.
  localparam int unsigned WB_SETTLE_1    = 7074;      // Above 4096: top parameter.
  localparam logic [13:0] WB_SETTLE_2    = 14'h0dc0;  // 3520 clocks.
  localparam logic [13:0] WB_SETTLE_3    = 14'h06e3;  // 1763 clocks.
  localparam logic [13:0] WB_SETTLE_4    = 14'h0a52;  // 2642 slow ticks.
  localparam logic [13:0] WB_SETTLE_5    = 14'h052c;  // 1324 slow ticks.

  // ****************************************************************
  // Output periods after settling, master clocks per result
  // ****************************************************************
  localparam logic [13:0] PERIOD_125K    = 14'h0100;
  localparam logic [13:0] PERIOD_250K    = 14'h0080;
  localparam logic [13:0] PERIOD_500K    = 14'h0040;
  localparam logic [13:0] PERIOD_1000K   = 14'h0020;
  localparam logic [13:0] PERIOD_2000K   = 14'h0010;
  localparam logic [13:0] PERIOD_4000K   = 14'h0008;

  localparam int unsigned HS_DIV_DEFAULT = 2;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_state_t;

endpackage

// ==== slow_tick_div.sv ====
// Enable divider producing the high-speed settling tick.
// Assumes the same clock and reset as the sequencer.
`timescale 1ns/100ps
module slow_tick_div #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  // Clearing aligns the tick phase with each accepted start.
  always_comb begin
    cnt_d  = cnt_q + W'(1);
    tick_d = 1'b0;
    if (clear_i) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule

// ==== conv_seq.sv ====
// Conversion start and filter settling sequencer of a delta-sigma converter.
// Assumes control pins arrive asynchronously and clock_i is the master clock.
`timescale 1ns/100ps
module conv_seq
  import conv_seq_pkg::*;
#(
  parameter int unsigned WB_SETTLE_125K = WB_SETTLE_0,
  parameter int unsigned WB_SETTLE_250K = WB_SETTLE_1,
  parameter int unsigned HS_DIV         = HS_DIV_DEFAULT
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic        filter_path_select_i,
  input  wire logic        low_latency_config_i,
  input  wire logic [2:0]  rate_select_i,
  output logic             result_ready_o,
  output logic             result_unsettled_o,
  output logic             low_latency_active_o,
  output logic             high_speed_mode_o,
  output logic             busy_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic       start_s1_q, start_s2_q, start_s3_q;
  logic       path_s1_q, path_s2_q, cfg_s1_q, cfg_s2_q;
  logic [2:0] rate_s1_q, rate_s2_q;

  // Pins are asynchronous to the master clock, so two flops come first.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
      path_s1_q  <= 1'b0;
      path_s2_q  <= 1'b0;
      cfg_s1_q   <= 1'b0;
      cfg_s2_q   <= 1'b0;
      rate_s1_q  <= RATE_125K;
      rate_s2_q  <= RATE_125K;
    end else begin
      start_s1_q <= start_i;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
      path_s1_q  <= filter_path_select_i;
      path_s2_q  <= path_s1_q;
      cfg_s1_q   <= low_latency_config_i;
      cfg_s2_q   <= cfg_s1_q;
      rate_s1_q  <= rate_select_i;
      rate_s2_q  <= rate_s1_q;
    end
  end

  logic start_rise;
  assign start_rise = start_s2_q & ~start_s3_q;

  // ****************************************************************
  // Timing lookups
  // ****************************************************************
  function automatic logic is_high_speed(input logic [2:0] rate);
    return (rate == RATE_2000K) || (rate == RATE_4000K);
  endfunction

  // Settling length; high-speed codes count slow ticks. Codes 110 and 111
  // are undefined and fall back to the 1000k figures.
  function automatic logic [CNT_W-1:0] settle_len(input logic ll, input logic [2:0] rate);
    logic [CNT_W-1:0] v;
    v = ll ? LL_SETTLE_3 : WB_SETTLE_3;
    case (rate)
      RATE_125K:  v = ll ? LL_SETTLE_0 : CNT_W'(WB_SETTLE_125K);
      RATE_250K:  v = ll ? LL_SETTLE_1 : CNT_W'(WB_SETTLE_250K);
      RATE_500K:  v = ll ? LL_SETTLE_2 : WB_SETTLE_2;
      RATE_2000K: v = ll ? LL_SETTLE_4 : WB_SETTLE_4;
      RATE_4000K: v = ll ? LL_SETTLE_5 : WB_SETTLE_5;
      default:    v = ll ? LL_SETTLE_3 : WB_SETTLE_3;
    endcase
    return v;
  endfunction

  function automatic logic [CNT_W-1:0] period_len(input logic [2:0] rate);
    logic [CNT_W-1:0] v;
    v = PERIOD_1000K;
    case (rate)
      RATE_125K:  v = PERIOD_125K;
      RATE_250K:  v = PERIOD_250K;
      RATE_500K:  v = PERIOD_500K;
      RATE_2000K: v = PERIOD_2000K;
      RATE_4000K: v = PERIOD_4000K;
      default:    v = PERIOD_1000K;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Slow settling tick
  // ****************************************************************
  logic hs_tick;

  slow_tick_div #(
    .DIV     (HS_DIV)
  ) u_div (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .clear_i (start_rise),
    .tick_o  (hs_tick)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  seq_state_t       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             ll_q, ll_d, fast_q, fast_d, hs_q, hs_d;
  logic [2:0]       rate_q, rate_d;
  logic             ready_q, ready_d, unsettled_q, unsettled_d;
  logic             ll_now, step;
  logic [CNT_W-1:0] limit;

  // Path decision: config low overrides the path pin.
  assign ll_now = (path_s2_q == PATH_LL) | ~cfg_s2_q;
  // High speed advances on slow ticks while settling, and for every conversion
  // in single-cycle settling, since each one spans a full settling time.
  assign step   = (hs_q && (state_q == ST_SETTLE || (ll_q && !fast_q))) ? hs_tick : 1'b1;
  // Single-cycle settling repeats the settle length as its period.
  assign limit  = (state_q == ST_SETTLE || (ll_q && !fast_q)) ?
                  settle_len(ll_q, rate_q) : period_len(rate_q);

  // Configuration is frozen at each accepted start; changes take effect
  // only on the next start, so stale-config results are the host's to drop.
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    ll_d        = ll_q;
    fast_d      = fast_q;
    hs_d        = hs_q;
    rate_d      = rate_q;
    ready_d     = 1'b0;
    unsettled_d = unsettled_q;
    if (start_rise) begin
      state_d     = ST_SETTLE;
      cnt_d       = '0;
      ll_d        = ll_now;
      fast_d      = (cfg_s2_q == CFG_FAST);
      hs_d        = is_high_speed(rate_s2_q);
      rate_d      = rate_s2_q;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_d = '0;
        end
        ST_SETTLE: begin
          if (step) begin
            if (cnt_q == limit - CNT_W'(1)) begin
              ready_d     = 1'b1;
              unsettled_d = hs_q & ll_q & fast_q;
              cnt_d       = '0;
              state_d     = start_s2_q ? ST_CONV : ST_IDLE;
            end else begin
              cnt_d = cnt_q + CNT_W'(1);
            end
          end
        end
        ST_CONV: begin
          if (step) begin
            if (cnt_q == limit - CNT_W'(1)) begin
              ready_d     = 1'b1;
              unsettled_d = 1'b0;
              cnt_d       = '0;
              state_d     = start_s2_q ? ST_CONV : ST_IDLE;
            end else begin
              cnt_d = cnt_q + CNT_W'(1);
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          cnt_d   = '0;
        end
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q     <= ST_IDLE;
      cnt_q       <= '0;
      ll_q        <= 1'b1;
      fast_q      <= 1'b0;
      hs_q        <= 1'b0;
      rate_q      <= RATE_125K;
      ready_q     <= 1'b0;
      unsettled_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      ll_q        <= ll_d;
      fast_q      <= fast_d;
      hs_q        <= hs_d;
      rate_q      <= rate_d;
      ready_q     <= ready_d;
      unsettled_q <= unsettled_d;
    end
  end

  // Status outputs, all registered.
  logic busy_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);
    end
  end

  assign result_ready_o       = ready_q;
  assign result_unsettled_o   = unsettled_q;
  assign low_latency_active_o = ll_q;
  assign high_speed_mode_o    = hs_q;
  assign busy_o               = busy_q;
endmodule

// ==== conv_seq_checker.sv ====
// Concurrent checks on the sequencer pins.
// Assumes the host holds configuration pins still around each start.
`timescale 1ns/100ps
module conv_seq_checker (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       start_i,
  input wire logic       filter_path_select_i,
  input wire logic       low_latency_config_i,
  input wire logic [2:0] rate_select_i,
  input wire logic       result_ready_o,
  input wire logic       result_unsettled_o,
  input wire logic       low_latency_active_o,
  input wire logic       high_speed_mode_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // A start rise held long enough to cross the synchroniser.
  sequence s_start;
    !start_i ##1 start_i [*4];
  endsequence
  // Leaving idle; configuration was synced three edges earlier.
  sequence s_begin;
    $rose(busy_o);
  endsequence
  a_start_taken: assert property (s_start |-> busy_o)
    else $error("start rise not taken");
  a_restart_quiet: assert property (s_start |-> !result_ready_o [*8])
    else $error("ready while resettling");
  a_path_select: assert property (s_begin ##0 $past(low_latency_config_i, 3)
    |-> low_latency_active_o == $past(filter_path_select_i, 3))
    else $error("path select not followed");
  a_path_forced: assert property (s_begin ##0 !$past(low_latency_config_i, 3)
    |-> low_latency_active_o)
    else $error("low-latency path not forced");
  a_speed_mode: assert property (s_begin
    |-> high_speed_mode_o == ($past(rate_select_i, 3) inside {3'h4, 3'h5}))
    else $error("speed mode wrong");
  a_ready_busy: assert property (result_ready_o |-> $past(busy_o))
    else $error("ready without conversion");
  a_ready_gap: assert property (result_ready_o |=> !result_ready_o [*7])
    else $error("results closer than eight clocks");
  a_unsettled_low: assert property (result_ready_o && !high_speed_mode_o
    |-> !result_unsettled_o)
    else $error("unsettled flag in low-speed mode");
endmodule
bind conv_seq conv_seq_checker chk (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i),
  .filter_path_select_i(filter_path_select_i), .low_latency_config_i(low_latency_config_i),
  .rate_select_i(rate_select_i), .result_ready_o(result_ready_o),
  .result_unsettled_o(result_unsettled_o), .low_latency_active_o(low_latency_active_o),
  .high_speed_mode_o(high_speed_mode_o), .busy_o(busy_o));

// ==== host_model.sv ====
// Host side of the control pins.
// Assumes callers step it at the falling clock edge.
`timescale 1ns/100ps
module host_model (
  output logic       start_o,
  output logic       path_o,
  output logic       cfg_o,
  output logic [2:0] rate_o
);
  // Start idles low; path and config idle high for the fast-response setup.
  initial begin
    start_o = 1'b0;
    path_o = 1'b1;
    cfg_o = 1'b1;
    rate_o = 3'h0;
  end
  // Configuration changes only while idle; a start strobe always follows.
  task automatic set_cfg(input logic c, input logic p, input logic [2:0] r);
    cfg_o = c;
    path_o = p;
    rate_o = r;
  endtask
  // One pulse per single conversion, held level for continuous runs.
  task automatic drive_start(input logic v);
    start_o = v;
  endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the conversion sequencer.
// Assumes the host model drives every pin at the falling clock edge.
`timescale 1ns/100ps
module tb;
  localparam int HSD = conv_seq_pkg::HS_DIV_DEFAULT;
  logic       clock_i;
  logic       nrst_i;
  logic       start_i;
  logic       fps;
  logic       llc;
  logic [2:0] rate;
  logic       rdy;
  logic       uns;
  logic       lla;
  logic       hsm;
  logic       busy;
  int         err_total;
  int         samples_checked;
  int         seed;
  host_model host (.start_o(start_i), .path_o(fps), .cfg_o(llc), .rate_o(rate));
  // Small wideband counts keep the slow rates short.
  conv_seq #(.WB_SETTLE_125K(40), .WB_SETTLE_250K(30)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i), .filter_path_select_i(fps),
    .low_latency_config_i(llc), .rate_select_i(rate), .result_ready_o(rdy),
    .result_unsettled_o(uns), .low_latency_active_o(lla), .high_speed_mode_o(hsm),
    .busy_o(busy));
  // Settling clocks from start acceptance to the first result.
  function automatic int settle(logic c, logic p, logic [2:0] r);
    int ll[8];
    int wb[8];
    ll = '{556, 300, 172, 116, 265 * HSD, 229 * HSD, 116, 116};
    wb = '{40, 30, 3520, 1763, 2642 * HSD, 1324 * HSD, 1763, 1763};
    return (!c || p) ? ll[r] : wb[r];
  endfunction
  // Clocks between back-to-back results.
  function automatic int period(logic c, logic p, logic [2:0] r);
    return !c ? settle(c, p, r) : (r > 3'h5 ? 32 : 256 >> r);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One start; optional hold for continuous mode or a second start mid-settle.
  task automatic run(logic c, logic p, logic [2:0] r, bit cont, bit again);
    int k;
    int n;
    int per;
    int tol;
    bit extra;
    n = settle(c, p, r);
    per = period(c, p, r);
    tol = (r inside {3'h4, 3'h5}) ? 2 : 0; // Slow tick phase is not exact.
    extra = 1'b0;
    host.set_cfg(c, p, r);
    repeat (8) @(negedge clock_i);
    host.drive_start(1'b1);
    k = 0;
    while (rdy !== 1'b1) begin
      @(negedge clock_i);
      k++;
      if (k == 4 && !cont) host.drive_start(1'b0);
      if (k == 50 && again) begin
        host.drive_start(1'b1);
        k = 0;
        again = 1'b0;
      end
      if (k > n + 20) begin
        err_total++;
        summarize();
      end
    end
    check(16'(k >= n + 3 - tol && k <= n + 3 + tol), 16'h1);
    check(lla, !c || p);
    check(hsm, r inside {3'h4, 3'h5});
    check(uns, c && p && tol > 0);
    if (cont) begin
      k = 0;
      do begin
        @(negedge clock_i);
        k++;
      end while (rdy !== 1'b1 && k < per + 20);
      // A result that never comes ends the whole simulation as a failure.
      if (rdy !== 1'b1) begin
        err_total++;
        summarize();
      end
      check(16'(k), 16'(per));
      check(uns, 1'b0);
      host.drive_start(1'b0);
    end
    k = 0;
    while (busy !== 1'b0) begin
      @(negedge clock_i);
      k++;
      if (k > per + 20) begin
        err_total++;
        summarize();
      end
    end
    repeat (per + 4) begin
      @(negedge clock_i);
      extra |= (rdy === 1'b1);
    end
    check(extra, 1'b0);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // Table sweep of every code, then corners and random setups.
  initial begin
    err_total = 0;
    samples_checked = 0;
    seed = 32'h5b15abb2;
    nrst_i = 1'b0;
    repeat (5) @(negedge clock_i);
    check({rdy, uns, lla, hsm, busy}, 16'h0004);
    nrst_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run(1'b0, 1'b1, 3'(i), 1'b0, 1'b0);
      run(1'b1, 1'b1, 3'(i), 1'b0, 1'b0);
      run(1'b1, 1'b0, 3'(i), 1'b0, 1'b0);
    end
    run(1'b0, 1'b0, 3'h3, 1'b0, 1'b0);
    run(1'b0, 1'b1, 3'h3, 1'b1, 1'b0);
    run(1'b1, 1'b1, 3'h5, 1'b1, 1'b0);
    run(1'b1, 1'b0, 3'h1, 1'b1, 1'b0);
    run(1'b1, 1'b1, 3'h0, 1'b0, 1'b1);
    run(1'b0, 1'b1, 3'h4, 1'b1, 1'b0);
    // Reset in mid-settle; start drops first so release brings no false rise.
    host.set_cfg(1'b1, 1'b1, 3'h0);
    host.drive_start(1'b1);
    repeat (20) @(negedge clock_i);
    host.drive_start(1'b0);
    nrst_i = 1'b0;
    @(negedge clock_i);
    check({rdy, uns, lla, hsm, busy}, 16'h0004);
    nrst_i = 1'b1;
    repeat (8) @(negedge clock_i);
    check({rdy, busy}, 16'h0000);
    repeat (6) run(1'($random(seed)), 1'($random(seed)), 3'($unsigned($random(seed)) % 6),
      1'b0, 1'b0);
    summarize();
  end
endmodule
